/* File: inc/dma_chan_pkg.sv */
// Behaviour
// - base address bits 2:0 always read zero
// - descriptors are 8 bytes, 32 per ring
// - current index counts descriptors, wraps 31 to 0
// - dword read at 04h returns three registers
// - status bits 4:2 clear by writing one
// - input overrun sets fault, drops sample
// - output underrun sets fault, repeats last sample
// - fault flagged only while buffers remain
// - buffer done flag when notify bit set
// - final buffer flag sticky, drives interrupt
// - at-final state set, cleared by index write
// - halted reads one when idle or finished
// - each channel instance has own registers
// - final buffer enable gates its interrupt
// - fault enable gates fault interrupt
// - run cleared blocks new bus requests; a finished buffer still steps the index
`default_nettype none
package dma_chan_pkg;
    // =====================================================
    // register byte offsets within one channel
    localparam logic [3:0] OFS_LIST_BASE = 4'h0;
    localparam logic [3:0] OFS_INDEX = 4'h4;
    localparam logic [3:0] OFS_POSITION = 4'h8;
    localparam int BYTE_LAST_VALID = 5;
    localparam int BYTE_STATUS = 6;
    localparam int BYTE_CONTROL = 11;
    // =====================================================
    // status bit positions and reset value
    localparam int ST_FIFO_FAULT = 4;
    localparam int ST_BUF_DONE = 3;
    localparam int ST_FINAL_EVT = 2;
    localparam int ST_AT_FINAL = 1;
    localparam int ST_HALTED = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0001;
    // =====================================================
    // control bit positions
    localparam int CR_RUN = 0;
    localparam int CR_RESET_REGS = 1;
    localparam int CR_FINAL_IE = 2;
    localparam int CR_FAULT_IE = 3;
    localparam int CR_DONE_IE = 4;
    // =====================================================
    // descriptor layout
    localparam int DESC_BYTES = 8;
    localparam int DESC_ENTRIES = 32;
    localparam int DESC_ADDR_LSB = 3;
    localparam logic [31:0] DESC_CTL_OFS = 32'h0000_0004;
    localparam int DESC_NOTIFY_BIT = 31;
    localparam logic [15:0] SAMPLES_PER_WORD = 16'h0002;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    // =====================================================
    // engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DESC_ADDR = 3'b001,
        ST_DESC_CTL = 3'b010,
        ST_XFER = 3'b011,
        ST_NEXT = 3'b100
    } engine_e;
endpackage : dma_chan_pkg
`default_nettype wire

/* File: logic/audio_descriptor_dma_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module audio_descriptor_dma_channel #(
    parameter bit IS_INPUT = 1'b0,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] ioAddr,
    input wire logic [3:0] ioByteEn,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [31:0] ioWdata,
    output logic [31:0] ioRdata,
    output logic ioRvalid,
    output logic memReq,
    output logic memWrite,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    input wire logic linkReq,
    input wire logic linkValid,
    input wire logic [31:0] linkData,
    output logic [31:0] linkSample,
    output logic linkSampleValid,
    output logic chanIrq
);
    import dma_chan_pkg::*;

    // =====================================================
    // channel state
    engine_e st_q;
    logic [31:DESC_ADDR_LSB] base_q;
    logic [4:0] civ_q;
    logic [4:0] lvi_q;
    logic [15:0] picb_q;
    logic [31:0] bufAddr_q;
    logic notify_q;
    logic advance_q;
    logic run_q;
    logic finalIe_q;
    logic faultIe_q;
    logic doneIe_q;
    logic fifoFault_q;
    logic bufDone_q;
    logic finalEvt_q;
    logic atFinal_q;
    logic halted_q;
    logic memReq_q;
    logic memWrite_q;
    logic [31:0] memAddr_q;
    logic [31:0] memWdata_q;
    logic [31:0] linkSample_q;
    logic linkSampleValid_q;
    logic chanIrq_q;
    logic [11:0] wrByte;
    logic chanClear;
    logic isLast;
    logic [31:0] descAddr;
    logic engIssue;
    logic enginePush;
    logic enginePop;
    logic linkPop;
    logic buffersRemain;
    logic evtFault;
    logic evtBufDone;
    logic evtFinal;
    logic evtAtFinal;
    logic fifoInValid;
    logic fifoInReady;
    logic [31:0] fifoInData;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [31:0] fifoOutData;
    logic [15:0] statusWord;
    logic [7:0] ctrlByte;
    logic [4:0] pivNow;

    // =====================================================
    // register port
    // one register set per instance
    reg_io_port uRegs (
        .mclk(mclk),
        .srst(srst),
        .ioAddr(ioAddr),
        .ioByteEn(ioByteEn),
        .ioWrite(ioWrite),
        .ioRead(ioRead),
        .dword0({base_q, 3'b000}),
        .dword1({statusWord, 3'b000, lvi_q, 3'b000, civ_q}),
        .dword2({ctrlByte, 3'b000, pivNow, picb_q}),
        .wrByte(wrByte),
        .ioRdata(ioRdata),
        .ioRvalid(ioRvalid)
    );

    // read views of status and control
    assign statusWord = {11'h000, fifoFault_q, bufDone_q, finalEvt_q, atFinal_q, halted_q};
    assign ctrlByte = {3'b000, doneIe_q, faultIe_q, finalIe_q, 1'b0, run_q};
    assign pivNow = civ_q + 5'h01;
    // reset-registers write acts like a reset for everything but run, the enables and the irq flop
    assign chanClear = srst | (wrByte[BYTE_CONTROL] & ioWdata[24 + CR_RESET_REGS]);

    // =====================================================
    // control byte; enables survive reset-registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            finalIe_q <= 1'b0;
            faultIe_q <= 1'b0;
            doneIe_q <= 1'b0;
        end else if (wrByte[BYTE_CONTROL]) begin
            finalIe_q <= ioWdata[24 + CR_FINAL_IE];
            faultIe_q <= ioWdata[24 + CR_FAULT_IE];
            doneIe_q <= ioWdata[24 + CR_DONE_IE];
        end
    end

    // run control
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_q <= 1'b0;
        end else if (wrByte[BYTE_CONTROL]) begin
            run_q <= ioWdata[24 + CR_RUN];
        end
    end

    // base and last valid index
    always_ff @(posedge mclk) begin
        if (chanClear) begin
            base_q <= '0;
            lvi_q <= 5'h00;
        end else begin
            if (wrByte[0]) base_q[7:3] <= ioWdata[7:3];
            if (wrByte[1]) base_q[15:8] <= ioWdata[15:8];
            if (wrByte[2]) base_q[23:16] <= ioWdata[23:16];
            if (wrByte[3]) base_q[31:24] <= ioWdata[31:24];
            if (wrByte[BYTE_LAST_VALID]) lvi_q <= ioWdata[12:8];
        end
    end

    // =====================================================
    // engine decode
    assign isLast = (civ_q == lvi_q);
    assign descAddr = {base_q, 3'b000} + {24'h000000, civ_q, 3'b000};
    assign engIssue = run_q & ~memReq_q;
    assign enginePush = (st_q == ST_XFER) & memAck & ~memWrite_q;
    assign enginePop = (st_q == ST_XFER) & memAck & memWrite_q;
    assign buffersRemain = (st_q != ST_IDLE);

    // descriptor walk and bus-master requests
    always_ff @(posedge mclk) begin
        if (chanClear) begin
            st_q <= ST_IDLE;
            civ_q <= 5'h00;
            picb_q <= 16'h0000;
            bufAddr_q <= 32'h0000_0000;
            notify_q <= 1'b0;
            advance_q <= 1'b0;
            memReq_q <= 1'b0;
            memWrite_q <= 1'b0;
            memAddr_q <= 32'h0000_0000;
            memWdata_q <= 32'h0000_0000;
        end else begin
            if (memAck) memReq_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    // wait for run and a new index
                    if (run_q && !atFinal_q && !memReq_q) begin
                        if (advance_q) civ_q <= civ_q + 5'h01;
                        advance_q <= 1'b0;
                        st_q <= ST_DESC_ADDR;
                    end
                end
                ST_DESC_ADDR: begin
                    if (engIssue) begin
                        memReq_q <= 1'b1;
                        memWrite_q <= 1'b0;
                        memAddr_q <= descAddr;
                    end
                    if (memAck) begin
                        bufAddr_q <= memRdata;
                        st_q <= ST_DESC_CTL;
                    end
                end
                ST_DESC_CTL: begin
                    if (engIssue) begin
                        memReq_q <= 1'b1;
                        memAddr_q <= descAddr + DESC_CTL_OFS;
                    end
                    if (memAck) begin
                        picb_q <= memRdata[15:0];
                        notify_q <= memRdata[DESC_NOTIFY_BIT];
                        st_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (picb_q == 16'h0000 && !memReq_q) begin
                        st_q <= ST_NEXT;
                    end else if (picb_q != 16'h0000 && engIssue) begin
                        if (!IS_INPUT && fifoInReady) begin
                            memReq_q <= 1'b1;
                            memWrite_q <= 1'b0;
                            memAddr_q <= bufAddr_q;
                        end else if (IS_INPUT && fifoOutValid) begin
                            memReq_q <= 1'b1;
                            memWrite_q <= 1'b1;
                            memAddr_q <= bufAddr_q;
                            memWdata_q <= fifoOutData;
                        end
                    end
                    if (memAck) begin
                        bufAddr_q <= bufAddr_q + WORD_BYTES;
                        picb_q <= (picb_q > SAMPLES_PER_WORD) ? picb_q - SAMPLES_PER_WORD
                                                               : 16'h0000;
                    end
                end
                ST_NEXT: begin
                    if (isLast) begin
                        advance_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end else begin
                        civ_q <= civ_q + 5'h01;
                        st_q <= ST_DESC_ADDR;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // status events
    assign evtBufDone = (st_q == ST_NEXT) & notify_q;
    assign evtAtFinal = (st_q == ST_NEXT) & isLast;
    // output flags at fetch, input after write-back
    assign evtFinal = IS_INPUT ? evtAtFinal : ((st_q == ST_DESC_CTL) & memAck & isLast);
    // faults count only while buffers remain
    assign evtFault = buffersRemain & (IS_INPUT ? (linkValid & ~fifoInReady)
                                                : (linkReq & ~fifoOutValid));

    // sticky flags; set wins over a clearing write
    always_ff @(posedge mclk) begin
        if (chanClear) begin
            fifoFault_q <= 1'b0;
            bufDone_q <= 1'b0;
            finalEvt_q <= 1'b0;
        end else begin
            fifoFault_q <= evtFault |
                (fifoFault_q & ~(wrByte[BYTE_STATUS] & ioWdata[16 + ST_FIFO_FAULT]));
            bufDone_q <= evtBufDone |
                (bufDone_q & ~(wrByte[BYTE_STATUS] & ioWdata[16 + ST_BUF_DONE]));
            finalEvt_q <= evtFinal |
                (finalEvt_q & ~(wrByte[BYTE_STATUS] & ioWdata[16 + ST_FINAL_EVT]));
        end
    end

    // at-final state and halted state
    always_ff @(posedge mclk) begin
        if (chanClear) begin
            atFinal_q <= 1'b0;
            halted_q <= STATUS_RESET[ST_HALTED];
        end else begin
            // held until a new last index is written
            atFinal_q <= evtAtFinal | (atFinal_q & ~wrByte[BYTE_LAST_VALID]);
            halted_q <= (st_q == ST_IDLE) | (~run_q & ~memReq_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            chanIrq_q <= 1'b0;
        end else begin
            chanIrq_q <= (finalEvt_q & finalIe_q) | (fifoFault_q & faultIe_q)
                       | (bufDone_q & doneIe_q);
        end
    end

    // =====================================================
    // fifo between bus master and link
    assign linkPop = ~IS_INPUT & linkReq & fifoOutValid;
    assign fifoInValid = IS_INPUT ? linkValid : enginePush;
    assign fifoInData = IS_INPUT ? linkData : memRdata;
    assign fifoOutReady = IS_INPUT ? enginePop : linkPop;

    // full fifo drops the link sample
    sample_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .mclk(mclk),
        .srst(chanClear),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // link side sample delivery
    always_ff @(posedge mclk) begin
        if (chanClear) begin
            linkSample_q <= 32'h0000_0000;
            linkSampleValid_q <= 1'b0;
        end else begin
            linkSampleValid_q <= ~IS_INPUT & linkReq;
            if (linkPop) linkSample_q <= fifoOutData;
        end
    end

    // =====================================================
    // outputs
    assign memReq = memReq_q;
    assign memWrite = memWrite_q;
    assign memAddr = memAddr_q;
    assign memWdata = memWdata_q;
    assign linkSample = linkSample_q;
    assign linkSampleValid = linkSampleValid_q;
    assign chanIrq = chanIrq_q;
endmodule : audio_descriptor_dma_channel
`default_nettype wire

/* File: logic/reg_io_port.sv */
`timescale 1ns/100ps
`default_nettype none
module reg_io_port (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] ioAddr,
    input wire logic [3:0] ioByteEn,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [31:0] dword0,
    input wire logic [31:0] dword1,
    input wire logic [31:0] dword2,
    output logic [11:0] wrByte,
    output logic [31:0] ioRdata,
    output logic ioRvalid
);
    import dma_chan_pkg::*;

    // =====================================================
    // byte enables to a 32-bit lane mask
    function automatic logic [31:0] laneMask(input logic [3:0] be);
        laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : laneMask

    // per-byte write strobes, four per dword
    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : gStrobe
            assign wrByte[g] = ioWrite & ioByteEn[g%4] & (ioAddr[3:2] == 2'(g/4));
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            ioRdata <= 32'h0000_0000;
            ioRvalid <= 1'b0;
        end else begin
            ioRvalid <= ioRead;
            if (ioRead) begin
                if (ioAddr[3:2] == OFS_LIST_BASE[3:2]) begin
                    ioRdata <= dword0 & laneMask(ioByteEn);
                end else if (ioAddr[3:2] == OFS_INDEX[3:2]) begin
                    ioRdata <= dword1 & laneMask(ioByteEn);
                end else if (ioAddr[3:2] == OFS_POSITION[3:2]) begin
                    ioRdata <= dword2 & laneMask(ioByteEn);
                end else begin
                    ioRdata <= 32'h0000_0000;
                end
            end
        end
    end
endmodule : reg_io_port
`default_nettype wire

/* File: logic/sample_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // =====================================================
    // handshakes; a full fifo leaves the write pointer untouched
    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem_q[rdPtr_q];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sample_fifo
`default_nettype wire

/* File: tb/dma_chan_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_chan_checker #(
    parameter bit IS_INPUT = 1'b0
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] ioAddr,
    input wire logic ioRead,
    input wire logic [31:0] ioRdata,
    input wire logic ioRvalid,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic memAck,
    input wire logic linkReq,
    input wire logic [31:0] linkSample,
    input wire logic linkSampleValid,
    input wire logic chanIrq
);
    // ==========================================
    // register port answers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    read_answer_a: assert property (ioRead |=> ioRvalid) else $error("read not answered");
    answer_cause_a: assert property (ioRvalid |-> $past(ioRead)) else $error("stray answer");
    rdata_hold_a: assert property (!ioRead |=> $stable(ioRdata)) else $error("rdata moved");
    base_low_a: assert property (ioRvalid && ($past(ioAddr) >> 2) == 4'h0 |-> ioRdata[2:0] == 3'h0)
        else $error("base low bits set");
    index_upper_a: assert property (ioRvalid && ($past(ioAddr) >> 2) == 4'h1
        |-> ioRdata[7:5] == 3'h0 && ioRdata[15:13] == 3'h0 && ioRdata[31:21] == 11'h000)
        else $error("hardwired bits set");
    // ==========================================
    // bus master and link
    req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
        else $error("request moved");
    req_drop_a: assert property (memReq && memAck |=> !memReq) else $error("request kept");
    word_align_a: assert property (memReq |-> memAddr[1:0] == 2'h0) else $error("misaligned");
    no_mem_write_a: assert property (!IS_INPUT && memReq |-> !memWrite) else $error("bad write");
    link_answer_a: assert property (!IS_INPUT && linkReq |=> linkSampleValid ##1 !linkSampleValid)
        else $error("link not answered");
    sample_hold_a: assert property (!linkReq |=> $stable(linkSample)) else $error("sample moved");
    cover property (memReq && memAck);
    cover property (linkSampleValid);
    cover property ($rose(chanIrq));
endmodule : dma_chan_checker
bind audio_descriptor_dma_channel dma_chan_checker #(.IS_INPUT(IS_INPUT)) chk_u (
    .mclk(mclk), .srst(srst), .ioAddr(ioAddr), .ioRead(ioRead), .ioRdata(ioRdata),
    .ioRvalid(ioRvalid), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memAck(memAck), .linkReq(linkReq), .linkSample(linkSample),
    .linkSampleValid(linkSampleValid), .chanIrq(chanIrq));
`default_nettype wire

/* File: tb/mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mem_model #(
    parameter logic [31:0] DESC_BASE = 32'h0000_0100
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    output logic memAck,
    output logic [31:0] memRdata,
    output logic [31:0] descReads,
    output logic [31:0] badAddr
);
    logic [1:0] waitCnt = 2'h0;
    logic slow = 1'b0;
    logic [4:0] expIdx = 5'h00;
    logic [31:0] word;
    logic isDesc;
    // ==========================================
    // ring: entry n points at 200h+10h*n, two samples, even entries notify
    assign isDesc = memAddr[31:8] == DESC_BASE[31:8];
    assign word = !isDesc ? {16'hDA7A, memAddr[15:0]} :
        memAddr[2] ? {!memAddr[3], 15'h0000, 16'h0002} :
        32'h0000_0200 + {23'h000000, memAddr[7:3], 4'h0};
    // ==========================================
    // answer fast and slow in turn, released bus shows inverted data
    initial begin
        memAck = 1'b0;
        memRdata = 32'h0000_0000;
        descReads = 32'h0;
        badAddr = 32'h0;
    end
    always @(posedge mclk) begin
        memAck <= 1'b0;
        if (srst) begin
            waitCnt <= 2'h0;
            expIdx <= 5'h00;
        end else if (memReq && !memAck) begin
            if (waitCnt == {slow, slow}) begin
                memAck <= 1'b1;
                memRdata <= word;
                waitCnt <= 2'h0;
                slow <= !slow;
                if (isDesc) begin
                    descReads <= descReads + 32'h1;
                    if (memAddr !== {DESC_BASE[31:8], expIdx, memAddr[2], 2'h0}) begin
                        badAddr <= badAddr + 32'h1;
                    end
                    if (memAddr[2]) begin
                        expIdx <= expIdx + 5'h01;
                    end
                end
            end else begin
                waitCnt <= waitCnt + 2'h1;
            end
        end else begin
            memRdata <= ~memRdata;
        end
    end
endmodule : mem_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] ioAddr = 4'h0;
    logic [3:0] ioByteEn = 4'h0;
    logic ioWrite = 1'b0;
    logic ioRead = 1'b0;
    logic [31:0] ioWdata = 32'h0;
    logic [31:0] ioRdata, memAddr, memWdata, memRdata, linkSample, descReads, badAddr, rd;
    logic ioRvalid, memReq, memWrite, memAck, linkSampleValid, chanIrq;
    logic linkReq = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int i;
    audio_descriptor_dma_channel #(.IS_INPUT(1'b0), .FIFO_DEPTH(16)) dut_u (
        .mclk(mclk), .srst(srst), .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRvalid(ioRvalid),
        .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata), .linkReq(linkReq), .linkValid(1'b0),
        .linkData(32'h0), .linkSample(linkSample), .linkSampleValid(linkSampleValid),
        .chanIrq(chanIrq));
    mem_model #(.DESC_BASE(32'h0000_0100)) mem_u (
        .mclk(mclk), .srst(srst), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memRdata(memRdata), .descReads(descReads), .badAddr(badAddr));
    // ==========================================
    // clock and hang guard
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    // ==========================================
    // access tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic io_write(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        ioAddr <= a;
        ioByteEn <= be;
        ioWdata <= d;
        ioWrite <= 1'b1;
        @(posedge mclk);
        ioWrite <= 1'b0;
    endtask : io_write
    task automatic io_read(input logic [3:0] a, input logic [3:0] be, output logic [31:0] d);
        @(posedge mclk);
        ioAddr <= a;
        ioByteEn <= be;
        ioRead <= 1'b1;
        @(posedge mclk);
        ioRead <= 1'b0;
        @(negedge mclk);
        d = ioRvalid === 1'b1 ? ioRdata : 32'hXXXX_XXXX;
    endtask : io_read
    task automatic link_pull(input logic [31:0] exp);
        @(posedge mclk);
        linkReq <= 1'b1;
        @(posedge mclk);
        linkReq <= 1'b0;
        @(negedge mclk);
        chk({31'h0, linkSampleValid}, 32'h1, "sample valid");
        chk(linkSample, exp, "sample word");
    endtask : link_pull
    task automatic wait_final();
        rd = 32'h0;
        // halted trails at-final by one cycle, so wait for both
        for (i = 0; i < 300 && rd[17:16] !== 2'b11; i++) begin
            io_read(4'h4, 4'hF, rd);
        end
    endtask : wait_final
    task automatic wrap_up();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        io_read(4'h0, 4'hF, rd);
        chk(rd, 32'h0000_0000, "base reset");
        io_read(4'h4, 4'hF, rd);
        chk(rd, 32'h0001_0000, "index dword reset");
        io_write(4'h0, 4'hF, 32'hFFFF_FFFF);
        io_read(4'h0, 4'hF, rd);
        chk(rd, 32'hFFFF_FFF8, "base low bits");
        io_write(4'h0, 4'hF, 32'h0000_0100);
        io_write(4'h4, 4'h3, 32'h0000_E1FF);
        io_read(4'h4, 4'h2, rd);
        chk(rd, 32'h0000_0100, "last index byte");
        io_read(4'h4, 4'hC, rd);
        chk(rd, 32'h0001_0000, "status halfword");
        io_write(4'h8, 4'h8, 32'h0500_0000);
        wait_final();
        chk(rd, 32'h000F_0101, "ring finished");
        chk({31'h0, chanIrq}, 32'h1, "final irq");
        chk(descReads, 32'h4, "descriptor reads");
        link_pull(32'hDA7A_0200);
        link_pull(32'hDA7A_0210);
        link_pull(32'hDA7A_0210);
        io_write(4'h4, 4'hC, 32'hFFE3_0000);
        io_read(4'h4, 4'hC, rd);
        chk(rd, 32'h000F_0000, "no fault when idle");
        io_write(4'h4, 4'hC, 32'h0004_0000);
        io_read(4'h4, 4'hC, rd);
        chk(rd, 32'h000B_0000, "final cleared");
        chk({31'h0, chanIrq}, 32'h0, "irq dropped");
        io_write(4'h4, 4'h2, 32'h0000_0200);
        io_read(4'h4, 4'hC, rd);
        chk({31'h0, rd[17]}, 32'h0, "at final cleared");
        wait_final();
        io_read(4'h4, 4'h1, rd);
        chk(rd, 32'h0000_0002, "index advanced");
        chk(descReads, 32'h6, "third descriptor");
        chk(badAddr, 32'h0, "descriptor addresses");
        chk(memWdata, 32'h0, "write data idle");
        link_pull(32'hDA7A_0220);
        io_write(4'h4, 4'hC, 32'h000C_0000);
        io_write(4'h8, 4'h8, 32'h0900_0000);
        io_write(4'h4, 4'h2, 32'h0000_0300);
        link_pull(32'hDA7A_0220);
        io_read(4'h4, 4'hC, rd);
        chk(rd, 32'h0010_0000, "fault while running");
        chk({31'h0, chanIrq}, 32'h1, "fault irq");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
